// >>> verilog/mdhcr_top.sv
// host control and status register bank of a motor driver behind a two-wire target port
module mdhcr_top (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [mdhcr_pkg::SPEED_W-1:0] speed_pin_cmd_i,
    input wire logic thermal_fault_i,
    input wire logic lowpower_state_i,
    input wire logic phase_overcurrent_i,
    input wire logic rotor_stall_i,
    input wire logic lowpower_request_i,
    output logic [mdhcr_pkg::SPEED_W-1:0] speed_command_o,
    output logic host_speed_select_o,
    output logic lowpower_enter_o,
    output logic config_write_enable_o,
    output logic nvm_reload_o,
    output logic nvm_program_o
);
    import mdhcr_pkg::*;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    mdhcr_pin_sync #(
        .IDLE_LEVEL(PIN_IDLE)
    ) u_scl_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .pin_i(scl_i),
        .level_o(scl_lvl),
        .rise_o(scl_rise),
        .fall_o(scl_fall)
    );
    mdhcr_pin_sync #(
        .IDLE_LEVEL(PIN_IDLE)
    ) u_sda_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .pin_i(sda_i),
        .level_o(sda_lvl),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );
    ////////////////////////////////////////////////////////////////
    // state
    mdhcr_state_e state_r;
    mdhcr_state_e state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic rw_r;
    logic rw_nxt;
    logic nack_r;
    logic nack_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic got_ptr_r;
    logic [7:0] ptr_r;
    logic [7:0] sp_low_r;
    logic sp_msb_r;
    logic host_speed_select_r;
    logic [SPEED_W-1:0] setpoint_r;
    logic [7:0] key_r;
    logic inhibit_r;
    logic cfg_wr_r;
    logic phase_overcurrent_flag_r;
    logic reload_r;
    logic program_r;
    logic [SPEED_W-1:0] speed_cmd_r;
    logic lowpower_enter_r;
    ////////////////////////////////////////////////////////////////
    // bus framing and strobes
    logic start_det;
    logic stop_det;
    logic byte_done;
    logic wr_ptr;
    logic wr_reg;
    logic tx_load;
    logic rd_status;
    logic [7:0] wr_data;
    assign start_det = scl_lvl & sda_fall;
    assign stop_det = scl_lvl & sda_rise;
    assign byte_done = (state_r == ST_RX) & scl_fall & (cnt_r == BITS_PER_BYTE);
    assign wr_ptr = byte_done & ~got_ptr_r;
    assign wr_reg = byte_done & got_ptr_r;
    assign wr_data = shift_r;
    assign tx_load = scl_fall & (((state_r == ST_ADDR_ACK) & rw_r) | ((state_r == ST_TX_ACK) & ~nack_r));
    assign rd_status = tx_load & (ptr_r == REG_STATUS);
    ////////////////////////////////////////////////////////////////
    // register decode
    logic wr_speed_low;
    logic wr_speed_high;
    logic wr_unlock;
    logic wr_nv_ctrl;
    logic key_armed;
    assign wr_speed_low = wr_reg & (ptr_r == REG_SPEED_LOW);
    assign wr_speed_high = wr_reg & (ptr_r == REG_SPEED_HIGH);
    assign wr_unlock = wr_reg & (ptr_r == REG_UNLOCK);
    assign wr_nv_ctrl = wr_reg & (ptr_r == REG_NV_CTRL);
    assign key_armed = (key_r == UNLOCK_KEY);
    ////////////////////////////////////////////////////////////////
    // read data
    logic [7:0] rd_speed_low;
    logic [7:0] rd_speed_high;
    logic [7:0] rd_nv_ctrl;
    logic [7:0] rd_status_byte;
    logic [7:0] rd_data;
    always_comb begin
        rd_speed_high = BYTE_ZERO;
        rd_speed_high[HOST_SPEED_SELECT_BIT] = host_speed_select_r;
        rd_speed_high[SP_MSB_BIT] = sp_msb_r;
        rd_nv_ctrl = BYTE_ZERO;
        rd_nv_ctrl[INHIBIT_BIT] = inhibit_r;
        rd_nv_ctrl[CFG_WR_BIT] = cfg_wr_r;
        rd_status_byte = BYTE_ZERO;
        rd_status_byte[THERMAL_BIT] = thermal_fault_i;
        rd_status_byte[LOWPWR_BIT] = lowpower_state_i;
        rd_status_byte[PHASE_OVERCURRENT_FLAG_BIT] = phase_overcurrent_flag_r;
        rd_status_byte[STALL_BIT] = rotor_stall_i;
    end
    assign rd_speed_low = sp_low_r;
    assign rd_data = (ptr_r == REG_SPEED_LOW) ? rd_speed_low :
                     (ptr_r == REG_SPEED_HIGH) ? rd_speed_high :
                     (ptr_r == REG_UNLOCK) ? key_r :
                     (ptr_r == REG_NV_CTRL) ? rd_nv_ctrl :
                     (ptr_r == REG_STATUS) ? rd_status_byte : BYTE_ZERO;
    ////////////////////////////////////////////////////////////////
    // two-wire target sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        sda_oe_nxt = sda_oe_r;
        if (stop_det) begin
            state_nxt = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (start_det) begin
            // a repeated start keeps the pointer for a combined read
            state_nxt = ST_ADDR;
            cnt_nxt = CNT_ZERO;
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    sda_oe_nxt = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_lvl};
                        cnt_nxt = cnt_r + CNT_ONE;
                    end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                        if (shift_r[7:1] == TARGET_ADDR) begin
                            state_nxt = ST_ADDR_ACK;
                            rw_nxt = shift_r[0];
                            sda_oe_nxt = 1'b1;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = CNT_ZERO;
                        if (rw_r) begin
                            state_nxt = ST_TX;
                            tx_nxt = rd_data;
                            sda_oe_nxt = ~rd_data[7];
                        end else begin
                            state_nxt = ST_RX;
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_lvl};
                        cnt_nxt = cnt_r + CNT_ONE;
                    end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                        state_nxt = ST_RX_ACK;
                        sda_oe_nxt = 1'b1;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        state_nxt = ST_RX;
                        cnt_nxt = CNT_ZERO;
                        sda_oe_nxt = 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == LAST_TX_FALL) begin
                            state_nxt = ST_TX_ACK;
                            sda_oe_nxt = 1'b0;
                        end else begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            sda_oe_nxt = ~tx_r[6];
                            cnt_nxt = cnt_r + CNT_ONE;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_nxt = sda_lvl;
                    end else if (scl_fall) begin
                        cnt_nxt = CNT_ZERO;
                        if (nack_r) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            state_nxt = ST_TX;
                            tx_nxt = rd_data;
                            sda_oe_nxt = ~rd_data[7];
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            shift_r <= BYTE_ZERO;
            tx_r <= BYTE_ZERO;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register pointer, auto-increments per data byte
    logic got_ptr_nxt;
    logic [7:0] ptr_nxt;
    assign got_ptr_nxt = start_det ? 1'b0 : (got_ptr_r | wr_ptr);
    assign ptr_nxt = wr_ptr ? wr_data : ((wr_reg | tx_load) ? ptr_r + 8'h01 : ptr_r);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            got_ptr_r <= 1'b0;
            ptr_r <= PTR_RST;
        end else begin
            got_ptr_r <= got_ptr_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // speed setpoint
    logic [7:0] sp_low_nxt;
    logic sp_msb_nxt;
    logic host_speed_select_nxt;
    logic [SPEED_W-1:0] setpoint_nxt;
    logic [SPEED_W-1:0] speed_cmd_nxt;
    assign sp_low_nxt = wr_speed_low ? wr_data : sp_low_r;
    assign sp_msb_nxt = wr_speed_high ? wr_data[SP_MSB_BIT] : sp_msb_r;
    assign host_speed_select_nxt = wr_speed_high ? wr_data[HOST_SPEED_SELECT_BIT] : host_speed_select_r;
    // msb alone never moves the motor; it waits for the low byte
    assign setpoint_nxt = wr_speed_low ? {sp_msb_r, wr_data} : setpoint_r;
    assign speed_cmd_nxt = host_speed_select_r ? setpoint_r : speed_pin_cmd_i;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp_low_r <= BYTE_ZERO;
            sp_msb_r <= 1'b0;
            host_speed_select_r <= 1'b0;
            setpoint_r <= SETPOINT_RST;
            speed_cmd_r <= SETPOINT_RST;
        end else begin
            sp_low_r <= sp_low_nxt;
            sp_msb_r <= sp_msb_nxt;
            host_speed_select_r <= host_speed_select_nxt;
            setpoint_r <= setpoint_nxt;
            speed_cmd_r <= speed_cmd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // unlock key and nonvolatile control
    logic [7:0] key_nxt;
    logic inhibit_nxt;
    logic cfg_wr_nxt;
    logic reload_nxt;
    logic program_nxt;
    logic phase_overcurrent_flag_nxt;
    // any register write other than the key itself consumes the key
    assign key_nxt = wr_unlock ? wr_data : (wr_reg ? BYTE_ZERO : key_r);
    assign inhibit_nxt = wr_nv_ctrl ? wr_data[INHIBIT_BIT] : inhibit_r;
    assign cfg_wr_nxt = wr_nv_ctrl ? wr_data[CFG_WR_BIT] : cfg_wr_r;
    assign reload_nxt = wr_nv_ctrl & wr_data[RELOAD_BIT];
    assign program_nxt = wr_nv_ctrl & wr_data[PROGRAM_BIT] & key_armed;
    // a new overcurrent in the reading cycle survives the clear
    assign phase_overcurrent_flag_nxt = phase_overcurrent_i | (phase_overcurrent_flag_r & ~rd_status);
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_r <= BYTE_ZERO;
            inhibit_r <= 1'b0;
            cfg_wr_r <= 1'b0;
            reload_r <= 1'b0;
            program_r <= 1'b0;
            phase_overcurrent_flag_r <= 1'b0;
            lowpower_enter_r <= 1'b0;
        end else begin
            key_r <= key_nxt;
            inhibit_r <= inhibit_nxt;
            cfg_wr_r <= cfg_wr_nxt;
            reload_r <= reload_nxt;
            program_r <= program_nxt;
            phase_overcurrent_flag_r <= phase_overcurrent_flag_nxt;
            lowpower_enter_r <= lowpower_request_i & ~inhibit_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign sda_o = SDA_DRIVE_LEVEL;
    assign sda_oe_o = sda_oe_r;
    assign speed_command_o = speed_cmd_r;
    assign host_speed_select_o = host_speed_select_r;
    assign lowpower_enter_o = lowpower_enter_r;
    assign config_write_enable_o = cfg_wr_r;
    assign nvm_reload_o = reload_r;
    assign nvm_program_o = program_r;
endmodule : mdhcr_top

// >>> verilog/mdhcr_pkg.sv
// constants and types shared by the motor drive host control register bank
package mdhcr_pkg;
    // target address on the two-wire port, arbitrary value
    localparam logic [6:0] TARGET_ADDR = 7'h2a;
    // register offsets
    localparam logic [7:0] REG_SPEED_LOW = 8'h00;
    localparam logic [7:0] REG_SPEED_HIGH = 8'h01;
    localparam logic [7:0] REG_UNLOCK = 8'h02;
    localparam logic [7:0] REG_NV_CTRL = 8'h03;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // field positions
    localparam int SPEED_W = 9;
    localparam int HOST_SPEED_SELECT_BIT = 7;
    localparam int SP_MSB_BIT = 0;
    localparam int INHIBIT_BIT = 7;
    localparam int CFG_WR_BIT = 6;
    localparam int RELOAD_BIT = 5;
    localparam int PROGRAM_BIT = 4;
    localparam int THERMAL_BIT = 7;
    localparam int LOWPWR_BIT = 6;
    localparam int PHASE_OVERCURRENT_FLAG_BIT = 5;
    localparam int STALL_BIT = 4;
    // values
    localparam logic [7:0] UNLOCK_KEY = 8'hb6;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [8:0] SETPOINT_RST = 9'h000;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_FALL = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic PIN_IDLE = 1'b1;
    localparam logic SDA_DRIVE_LEVEL = 1'b0;
    // two-wire target states, gray along address, write and read paths
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_RX = 3'b010,
        ST_RX_ACK = 3'b110,
        ST_TX = 3'b111,
        ST_TX_ACK = 3'b101
    } mdhcr_state_e;
endpackage : mdhcr_pkg

// >>> verilog/mdhcr_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
module mdhcr_pin_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic rise_r;
    logic fall_r;
    logic agree;
    logic level_nxt;

    ////////////////////////////////////////////////////////////////
    // a change counts only once the second and third stages agree
    assign agree = (s2_r == s3_r);
    assign level_nxt = agree ? s3_r : level_r;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_r <= IDLE_LEVEL;
            s2_r <= IDLE_LEVEL;
            s3_r <= IDLE_LEVEL;
            level_r <= IDLE_LEVEL;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            rise_r <= level_nxt & ~level_r;
            fall_r <= ~level_nxt & level_r;
        end
    end

    assign level_o = level_r;
    assign rise_o = rise_r;
    assign fall_o = fall_r;
endmodule : mdhcr_pin_sync

// >>> sim/mdhcr_checker.sv
// port-level assertions for the motor drive host control register bank
module mdhcr_checker (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic sda_oe_o,
    input wire logic [mdhcr_pkg::SPEED_W-1:0] speed_pin_cmd_i,
    input wire logic lowpower_request_i,
    input wire logic [mdhcr_pkg::SPEED_W-1:0] speed_command_o,
    input wire logic host_speed_select_o,
    input wire logic lowpower_enter_o,
    input wire logic config_write_enable_o,
    input wire logic nvm_reload_o,
    input wire logic nvm_program_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mdhcr_pkg::*;
    ////////////////////////////////////////
    // settle counter, $past still sees reset values just after release
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    logic armed;
    assign up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    assign armed = (up_r == 2'h3);
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up_r <= 2'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////
    pin_path_a: assert property (
        armed && !host_speed_select_o && !$past(host_speed_select_o) |-> speed_command_o == $past(speed_pin_cmd_i))
        else $error("speed command not from pin path");
    select_ack_a: assert property (
        armed && $changed(host_speed_select_o) |-> sda_oe_o)
        else $error("host_speed_select changed outside a write");
    setpoint_hold_a: assert property (
        armed && $changed(speed_command_o) && host_speed_select_o && $past(host_speed_select_o, 2)
        |-> $past(sda_oe_o))
        else $error("host setpoint changed without a write");
    lowpower_gate_a: assert property (
        lowpower_enter_o |-> $past(lowpower_request_i))
        else $error("low-power entry without request");
    cfg_ack_a: assert property (
        armed && $changed(config_write_enable_o) |-> sda_oe_o)
        else $error("config enable changed outside a write");
    reload_pulse_a: assert property (
        nvm_reload_o |-> sda_oe_o ##1 !nvm_reload_o)
        else $error("reload pulse malformed");
    prog_pulse_a: assert property (
        $rose(nvm_program_o) |=> $fell(nvm_program_o))
        else $error("program pulse longer than one cycle");
    prog_ack_a: assert property (
        nvm_program_o |-> sda_oe_o [*4])
        else $error("program pulse outside a write ack");
    cover property (nvm_program_o);
    cover property (nvm_reload_o);
    cover property ($rose(host_speed_select_o));
    cover property (lowpower_enter_o);
endmodule : mdhcr_checker

bind mdhcr_top mdhcr_checker u_mdhcr_checker (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .sda_oe_o(sda_oe_o),
    .speed_pin_cmd_i(speed_pin_cmd_i),
    .lowpower_request_i(lowpower_request_i),
    .speed_command_o(speed_command_o),
    .host_speed_select_o(host_speed_select_o),
    .lowpower_enter_o(lowpower_enter_o),
    .config_write_enable_o(config_write_enable_o),
    .nvm_reload_o(nvm_reload_o),
    .nvm_program_o(nvm_program_o)
);

// >>> sim/mdhcr_host_model.sv
// two-wire host model issuing register writes and reads
module mdhcr_host_model (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_drive_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mdhcr_pkg::*;
    // quarter scl period; keeps sda edges well clear of scl edges
    localparam int QTR = 10;
    initial begin
        scl_o = PIN_IDLE;
        sda_drive_o = 1'b0;
    end
    task automatic q();
        repeat (QTR) @(posedge sys_clk_i);
    endtask : q
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_drive_o <= ~b;
        q();
        scl_o <= 1'b1;
        q();
        r = sda_i;
        q();
        scl_o <= 1'b0;
    endtask : bit_io
    // doubles as repeated start: scl is low after every ack slot
    task automatic start();
        q();
        sda_drive_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_drive_o <= 1'b1;
        q();
        scl_o <= 1'b0;
    endtask : start
    task automatic stop();
        q();
        sda_drive_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_drive_o <= 1'b0;
        q();
    endtask : stop
    task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(ack_in, r);
        acked = ~r;
    endtask : byte_io
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        byte_io({TARGET_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(ptr, 1'b1, rx, a1);
        byte_io(d, 1'b1, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : write_reg
    // single byte read, ended by a nack from the host
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        byte_io({TARGET_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(ptr, 1'b1, rx, a1);
        start();
        byte_io({TARGET_ADDR, 1'b1}, 1'b1, rx, a2);
        byte_io(8'hff, 1'b1, d, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : mdhcr_host_model

// >>> sim/tb_top.sv
// self-checking bench for the motor drive host control register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mdhcr_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic scl_w, host_drive, sda_o, sda_oe_o, sda_w;
    logic [SPEED_W-1:0] speed_pin_cmd_i = 9'h000;
    logic thermal_fault_i = 1'b0;
    logic lowpower_state_i = 1'b0;
    logic phase_overcurrent_i = 1'b0;
    logic rotor_stall_i = 1'b0;
    logic lowpower_request_i = 1'b0;
    logic [SPEED_W-1:0] speed_command_o;
    logic host_speed_select_o, lowpower_enter_o, config_write_enable_o, nvm_reload_o, nvm_program_o;
    logic [8:0] prog_cnt = 9'h000;
    logic [8:0] reload_cnt = 9'h000;
    int num_errors = 0;
    int num_checks = 0;
    int seed = 32'h91b4c118;
    // open drain with pull-up
    assign sda_w = ~(host_drive | (sda_oe_o & ~sda_o));
    always #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (nvm_program_o === 1'b1) prog_cnt <= prog_cnt + 9'h001;
        if (nvm_reload_o === 1'b1) reload_cnt <= reload_cnt + 9'h001;
    end
    mdhcr_top u_mdhcr_top (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .scl_i(scl_w), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .speed_pin_cmd_i(speed_pin_cmd_i), .thermal_fault_i(thermal_fault_i),
        .lowpower_state_i(lowpower_state_i), .phase_overcurrent_i(phase_overcurrent_i),
        .rotor_stall_i(rotor_stall_i), .lowpower_request_i(lowpower_request_i), .speed_command_o(speed_command_o),
        .host_speed_select_o(host_speed_select_o), .lowpower_enter_o(lowpower_enter_o),
        .config_write_enable_o(config_write_enable_o), .nvm_reload_o(nvm_reload_o), .nvm_program_o(nvm_program_o));
    mdhcr_host_model u_host (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_drive_o(host_drive));
    ////////////////////////////////////////
    function automatic logic [7:0] f_hi(input logic [7:0] d);
        return {d[HOST_SPEED_SELECT_BIT], 6'h00, d[SP_MSB_BIT]};
    endfunction : f_hi
    function automatic logic [7:0] f_st(input logic oc);
        return {thermal_fault_i, lowpower_state_i, oc, rotor_stall_i, 4'h0};
    endfunction : f_st
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic chk1(input logic got, input logic exp);
        check({8'h00, got}, {8'h00, exp});
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_host.write_reg(a, d, ok);
        chk1(ok, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        u_host.read_reg(a, d, ok);
        check({ok, d}, {1'b1, e});
    endtask : rd
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    initial begin
        logic [7:0] lo, hi, d;
        logic [8:0] sp_exp, p0, r0;
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        for (int a = 0; a < 4; a++) begin
            rd(8'(a), BYTE_ZERO);
        end
        rd(8'h20, BYTE_ZERO);
        speed_pin_cmd_i <= 9'($random(seed));
        repeat (3) @(posedge sys_clk_i);
        check(speed_command_o, speed_pin_cmd_i);
        $display("test reset done");
        sp_exp = SETPOINT_RST;
        for (int n = 0; n < 3; n++) begin
            hi = 8'($random(seed)) | 8'h80;
            lo = (n == 2) ? 8'hff : 8'($random(seed));
            wr(REG_SPEED_HIGH, hi);
            check(speed_command_o, sp_exp);
            chk1(host_speed_select_o, 1'b1);
            wr(REG_SPEED_LOW, lo);
            sp_exp = {hi[SP_MSB_BIT], lo};
            check(speed_command_o, sp_exp);
            rd(REG_SPEED_HIGH, f_hi(hi));
        end
        rd(REG_SPEED_LOW, lo);
        wr(REG_SPEED_HIGH, 8'h01);
        check(speed_command_o, speed_pin_cmd_i);
        $display("test speed done");
        p0 = prog_cnt;
        wr(REG_UNLOCK, UNLOCK_KEY);
        rd(REG_UNLOCK, UNLOCK_KEY);
        wr(REG_NV_CTRL, 8'h10);
        check(prog_cnt - p0, 9'h001);
        wr(REG_UNLOCK, UNLOCK_KEY ^ 8'h01);
        wr(REG_NV_CTRL, 8'h10);
        check(prog_cnt - p0, 9'h001);
        wr(REG_UNLOCK, UNLOCK_KEY);
        wr(REG_SPEED_LOW, lo);
        rd(REG_UNLOCK, BYTE_ZERO);
        wr(REG_NV_CTRL, 8'h10);
        check(prog_cnt - p0, 9'h001);
        $display("test unlock done");
        lowpower_request_i <= 1'b1;
        r0 = reload_cnt;
        d = 8'($random(seed)) | 8'he0;
        wr(REG_NV_CTRL, d);
        check(reload_cnt - r0, 9'h001);
        chk1(config_write_enable_o, 1'b1);
        chk1(lowpower_enter_o, 1'b0);
        rd(REG_NV_CTRL, {d[7:6], 6'h00});
        wr(REG_NV_CTRL, BYTE_ZERO);
        chk1(lowpower_enter_o, 1'b1);
        chk1(config_write_enable_o, 1'b0);
        check(reload_cnt - r0, 9'h001);
        check(prog_cnt - p0, 9'h001);
        $display("test nvm control done");
        {thermal_fault_i, lowpower_state_i, rotor_stall_i} <= 3'($random(seed));
        phase_overcurrent_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        phase_overcurrent_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        rd(REG_STATUS, f_st(1'b1));
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, f_st(1'b0));
        $display("test status done");
        wrap_up();
    end
    initial begin
        repeat (80000) @(posedge sys_clk_i);
        num_errors++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : tb_top
